// [verilog/eea_pkg.sv]
// constants, types and field layout for the data nonvolatile byte access block
// assumes a single 40 MHz core clock shared by software register writes and this block
package eea_pkg;
	localparam int CLK_MHZ = 40;
	localparam int ADDR_W = 10;
	localparam int ADDR_HI_W = ADDR_W - 8;
	localparam int MEM_DEPTH = 1024;
	// control register bit positions
	localparam int CTL_MEMSEL_BIT = 7;
	localparam int CTL_PERMIT_BIT = 2;
	localparam int CTL_WRTRIG_BIT = 1;
	localparam int CTL_RDTRIG_BIT = 0;
	localparam logic [7:0] UNLOCK_FIRST = 8'h55;
	localparam logic [7:0] UNLOCK_SECOND = 8'haa;
	// reset values
	localparam logic [7:0] ADDR_RST = 8'h00;
	localparam logic [7:0] DATA_RST = 8'h00;
	localparam logic CTL_BIT_RST = 1'b0;
	// self-timed write duration in microseconds
	localparam int WRITE_TIME_US = 4000;
	localparam int WRITE_CYCLES_DFLT = WRITE_TIME_US * CLK_MHZ;
	localparam int CNT_W = 18;

	typedef enum logic [3:0] {
		EEA_SEL_ADDR_HI = 4'h1,
		EEA_SEL_ADDR_LO = 4'h2,
		EEA_SEL_DATA = 4'h4,
		EEA_SEL_CTRL = 4'h8
	} eea_sel_t;

	typedef enum logic [1:0] {
		EEA_UNLOCK = 2'h1,
		EEA_UNLOCK_FIRST_OK = 2'h2
	} eea_unlock_t;

	typedef enum logic [1:0] {
		EEA_IDLE = 2'h1,
		EEA_BUSY = 2'h2
	} eea_state_t;

	// one software register write, or an unlock-register write when unlock_wr is set
	typedef struct packed {
		logic valid;
		logic unlock_wr;
		eea_sel_t sel;
		logic [7:0] data;
	} eea_sw_wr_t;

	typedef struct packed {
		logic memory_select_bit;
		logic write_permit_bit;
		logic write_trig;
		logic read_trig;
	} eea_ctrl_t;
endpackage : eea_pkg

// [verilog/eea_data_access.sv]
// byte read/write control for the on-chip data nonvolatile array, with unlock and lockout
// assumes software writes arrive on the core clock; low_power_crystal_mode is core-clock logic
`timescale 1ns/1ps
`default_nettype none
module eea_data_access #(
	parameter int WRITE_CYCLES = eea_pkg::WRITE_CYCLES_DFLT
) (
	input wire logic clk_sys,
	input wire logic srst,
	input wire logic ce,
	input wire eea_pkg::eea_sw_wr_t sw_wr,
	input wire logic done_clr,
	input wire logic low_power_crystal_mode,
	output logic [eea_pkg::ADDR_HI_W-1:0] ee_address_high,
	output logic [7:0] ee_address_low,
	output logic [7:0] ee_byte_register,
	output eea_pkg::eea_ctrl_t ee_control_register,
	output logic write_done_flag,
	output logic high_power_req,
	output logic write_busy
);
	import eea_pkg::*;

	localparam logic [CNT_W-1:0] WR_LAST = CNT_W'(WRITE_CYCLES - 1);

	logic [7:0] mem [MEM_DEPTH];
	logic [ADDR_HI_W-1:0] addr_hi_reg;
	logic [7:0] addr_lo_reg;
	logic [7:0] data_reg;
	eea_ctrl_t ctrl_reg;
	logic done_reg;
	logic hp_reg;
	eea_state_t state_reg;
	eea_unlock_t unlock_reg;
	logic [CNT_W-1:0] cnt_reg;
	logic sw_reg_wr;
	logic ctrl_wr;
	logic start_wr;
	logic finish_wr;
	logic [ADDR_W-1:0] addr;

	assign addr = {addr_hi_reg, addr_lo_reg};
	// software register writes are dropped while a write runs
	assign sw_reg_wr = ce && sw_wr.valid && !sw_wr.unlock_wr && state_reg == EEA_IDLE;
	assign ctrl_wr = sw_reg_wr && sw_wr.sel == EEA_SEL_CTRL;
	// permit must already be set; the incoming byte's permit bit does not count
	assign start_wr = ctrl_wr && sw_wr.data[CTL_WRTRIG_BIT] && ctrl_reg.write_permit_bit
		&& !ctrl_reg.memory_select_bit;
	assign finish_wr = ce && state_reg == EEA_BUSY && !low_power_crystal_mode && cnt_reg == WR_LAST;

	// unlock sequencer: any other write breaks the sequence, one unlock covers one byte
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			unlock_reg <= EEA_UNLOCK;
		end else if (ce && sw_wr.valid) begin
			if (sw_wr.unlock_wr && sw_wr.data == UNLOCK_FIRST) begin
				unlock_reg <= EEA_UNLOCK_FIRST_OK;
			end else begin
				// 0xaa ends the first step too, so a repeated 0xaa cannot arm again
				unlock_reg <= EEA_UNLOCK;
			end
		end
	end

	// second unlock byte arms; tracked separately so 0x55 alone never arms
	logic armed_reg;
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			armed_reg <= 1'b0;
		end else if (ce && sw_wr.valid) begin
			armed_reg <= sw_wr.unlock_wr && sw_wr.data == UNLOCK_SECOND
				&& unlock_reg == EEA_UNLOCK_FIRST_OK && !armed_reg;
		end
	end

	logic start_ok;
	assign start_ok = start_wr && armed_reg;

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			addr_hi_reg <= ADDR_HI_W'(ADDR_RST);
			addr_lo_reg <= ADDR_RST;
		end else if (sw_reg_wr && sw_wr.sel == EEA_SEL_ADDR_HI) begin
			addr_hi_reg <= sw_wr.data[ADDR_HI_W-1:0];
		end else if (sw_reg_wr && sw_wr.sel == EEA_SEL_ADDR_LO) begin
			addr_lo_reg <= sw_wr.data;
		end
	end

	// data register: software write or fetched byte, otherwise held
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			data_reg <= DATA_RST;
		end else if (ce && ctrl_reg.read_trig) begin
			data_reg <= mem[addr];
		end else if (sw_reg_wr && sw_wr.sel == EEA_SEL_DATA) begin
			data_reg <= sw_wr.data;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (ce && finish_wr) begin
			mem[addr] <= data_reg;
		end
	end

	// control register
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			ctrl_reg <= '{CTL_BIT_RST, CTL_BIT_RST, CTL_BIT_RST, CTL_BIT_RST};
		end else if (ce) begin
			if (ctrl_wr) begin
				ctrl_reg.memory_select_bit <= sw_wr.data[CTL_MEMSEL_BIT];
				ctrl_reg.write_permit_bit <= sw_wr.data[CTL_PERMIT_BIT];
				ctrl_reg.write_trig <= start_ok;
				// a read in the byte that starts a write would disturb the locked data register
				ctrl_reg.read_trig <= sw_wr.data[CTL_RDTRIG_BIT] && !sw_wr.data[CTL_MEMSEL_BIT]
					&& !start_ok;
			end else begin
				ctrl_reg.read_trig <= 1'b0;
				if (finish_wr) begin
					ctrl_reg.write_trig <= 1'b0;
				end
			end
		end
	end

	// write timer; it waits while the core still runs in low-power crystal mode
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			state_reg <= EEA_IDLE;
			cnt_reg <= '0;
		end else if (ce) begin
			unique case (state_reg)
				EEA_IDLE: begin
					cnt_reg <= '0;
					if (start_ok) begin
						state_reg <= EEA_BUSY;
					end
				end
				EEA_BUSY: begin
					if (finish_wr) begin
						state_reg <= EEA_IDLE;
					end else if (!low_power_crystal_mode) begin
						cnt_reg <= cnt_reg + CNT_W'(1);
					end
				end
			endcase
		end
	end

	always_ff @(posedge clk_sys) begin
		if (srst) begin
			hp_reg <= 1'b0;
		end else if (ce && start_ok) begin
			hp_reg <= 1'b1;
		end else if (finish_wr) begin
			hp_reg <= 1'b0;
		end
	end

	// done flag: set wins over a same-cycle clear
	always_ff @(posedge clk_sys) begin
		if (srst) begin
			done_reg <= 1'b0;
		end else if (finish_wr) begin
			done_reg <= 1'b1;
		end else if (ce && done_clr) begin
			done_reg <= 1'b0;
		end
	end

	assign ee_address_high = addr_hi_reg;
	assign ee_address_low = addr_lo_reg;
	assign ee_byte_register = data_reg;
	assign ee_control_register = ctrl_reg;
	assign write_done_flag = done_reg;
	assign high_power_req = hp_reg;
	// one-hot busy code is bit 1 of the state flop
	assign write_busy = state_reg[1];

	logic [7:0] rd_word;
	assign rd_word = mem[addr];

	a_read_latency: assert property (@(posedge clk_sys) disable iff (srst)
		ce && ctrl_reg.read_trig |=> data_reg == $past(rd_word) && !ctrl_reg.read_trig)
		else $error("read byte not fetched one cycle after trigger");
	a_no_unlock_no_start: assert property (@(posedge clk_sys) disable iff (srst)
		state_reg == EEA_IDLE && !armed_reg |=> state_reg == EEA_IDLE)
		else $error("write started without unlock sequence");
	a_permit_needed: assert property (@(posedge clk_sys) disable iff (srst)
		state_reg == EEA_IDLE && !ctrl_reg.write_permit_bit |=> state_reg == EEA_IDLE && !ctrl_reg.write_trig)
		else $error("write started without prior permit");
	a_permit_kept: assert property (@(posedge clk_sys) disable iff (srst)
		ctrl_reg.write_permit_bit && !ctrl_wr |=> ctrl_reg.write_permit_bit)
		else $error("hardware cleared write permit");
	a_lock_busy: assert property (@(posedge clk_sys) disable iff (srst)
		state_reg == EEA_BUSY && !finish_wr |=> $stable(addr) && $stable(data_reg) && $stable(ctrl_reg))
		else $error("registers changed during write");
	a_write_end: assert property (@(posedge clk_sys) disable iff (srst)
		finish_wr |=> !ctrl_reg.write_trig && done_reg && state_reg == EEA_IDLE && !hp_reg
			&& mem[$past(addr)] == $past(data_reg))
		else $error("write end did not clear trigger and set done");
	a_done_sticky: assert property (@(posedge clk_sys) disable iff (srst)
		done_reg && !done_clr |=> done_reg)
		else $error("done flag cleared by hardware");
	a_high_power: assert property (@(posedge clk_sys) disable iff (srst)
		start_ok |=> hp_reg && state_reg == EEA_BUSY && cnt_reg == '0)
		else $error("write start did not request high power");
	a_lowpower_stall: assert property (@(posedge clk_sys) disable iff (srst)
		state_reg == EEA_BUSY && low_power_crystal_mode |=> $stable(cnt_reg))
		else $error("write timer advanced in low-power mode");
	c_read: cover property (@(posedge clk_sys) disable iff (srst) ce && ctrl_reg.read_trig ##1 !ctrl_reg.read_trig);
	c_write_done: cover property (@(posedge clk_sys) disable iff (srst) finish_wr);
	c_bad_unlock: cover property (@(posedge clk_sys) disable iff (srst) ctrl_wr && sw_wr.data[CTL_WRTRIG_BIT] && !start_ok);
endmodule : eea_data_access
`default_nettype wire

// [testbench/data_eeprom_access_control_tb_top.sv]
// self-checking bench for the data nonvolatile byte access block
// assumes eea_pkg and eea_data_access are compiled first
`timescale 1ns/1ps
`default_nettype none
module data_eeprom_access_control_tb_top;
	import eea_pkg::*;
	logic clk_sys = 1'b0, srst = 1'b1, ce = 1'b1, done_clr = 1'b0, slow_osc = 1'b0;
	eea_sw_wr_t sw_wr = '0;
	logic [1:0] a_hi;
	logic [7:0] a_lo, dbyte;
	eea_ctrl_t ctl;
	logic done, hp, busy;
	int errors = 0, checked = 0, cyc = 0;
	eea_data_access #(.WRITE_CYCLES(8)) DUT (.clk_sys(clk_sys), .srst(srst), .ce(ce), .sw_wr(sw_wr),
		.done_clr(done_clr), .low_power_crystal_mode(slow_osc), .ee_address_high(a_hi), .ee_address_low(a_lo),
		.ee_byte_register(dbyte), .ee_control_register(ctl), .write_done_flag(done), .high_power_req(hp),
		.write_busy(busy));
	initial begin
		forever #12.5 clk_sys = ~clk_sys;
	end
	task automatic tally_and_finish;
		$display("comparisons %0d mismatches %0d", checked, errors);
		if (errors == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	always @(posedge clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 3000) begin
			errors = errors + 1;
			tally_and_finish();
		end
	end
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		checked = checked + 1;
		if (got !== exp) begin
			errors = errors + 1;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic wr(input eea_sel_t s, input logic [7:0] d, input logic u = 1'b0);
		@(negedge clk_sys);
		sw_wr = '{1'b1, u, s, d};
	endtask
	task automatic idle;
		@(negedge clk_sys);
		sw_wr.valid = 1'b0;
	endtask
	task automatic set_addr(input logic [1:0] hi, input logic [7:0] lo);
		wr(EEA_SEL_ADDR_HI, {6'h00, hi});
		wr(EEA_SEL_ADDR_LO, lo);
	endtask
	task automatic reset_check;
		repeat (16) @(negedge clk_sys);
		srst = 1'b0;
		chk({a_hi, a_lo, dbyte}, 16'h0000);
		chk({ctl, done, hp, busy}, 16'h0000);
		$display("reset test done");
	endtask
	task automatic do_write(input logic [1:0] hi, input logic [7:0] lo, input logic [7:0] d, input logic slow);
		int n;
		set_addr(hi, lo);
		wr(EEA_SEL_DATA, d);
		wr(EEA_SEL_CTRL, 8'h04);
		wr(EEA_SEL_CTRL, UNLOCK_FIRST, 1'b1);
		wr(EEA_SEL_CTRL, UNLOCK_SECOND, 1'b1);
		slow_osc = slow;
		wr(EEA_SEL_CTRL, 8'h06);
		idle();
		chk({ctl.write_trig, busy, hp}, 16'h0007);
		wr(EEA_SEL_DATA, 8'h11);
		wr(EEA_SEL_CTRL, 8'h00);
		wr(EEA_SEL_ADDR_LO, ~lo);
		idle();
		chk({a_lo, dbyte}, {lo, d});
		chk(ctl.write_permit_bit, 1'b1);
		if (slow) begin
			repeat (12) @(negedge clk_sys);
			chk({busy, hp}, 16'h0003);
			slow_osc = 1'b0;
		end
		n = 0;
		while (busy === 1'b1 && n < 100) begin
			@(negedge clk_sys);
			n++;
		end
		chk({ctl.write_trig, done, busy, hp}, 16'h0004);
		chk(ctl.write_permit_bit, 1'b1);
		wr(EEA_SEL_CTRL, 8'h06);
		idle();
		chk({ctl.write_trig, busy, done}, 16'h0001);
		done_clr = 1'b1;
		@(negedge clk_sys);
		done_clr = 1'b0;
		chk(done, 1'b0);
		wr(EEA_SEL_CTRL, 8'h00);
		idle();
		chk(ctl.write_permit_bit, 1'b0);
		$display("write test done");
	endtask
	task automatic read_back(input logic [1:0] hi, input logic [7:0] lo, input logic [7:0] exp);
		set_addr(hi, lo);
		wr(EEA_SEL_DATA, ~exp);
		wr(EEA_SEL_CTRL, 8'h01);
		idle();
		chk(ctl.read_trig, 1'b1);
		@(negedge clk_sys);
		chk({dbyte, ctl.read_trig}, {7'h00, exp, 1'b0});
		repeat (5) @(negedge clk_sys);
		chk(dbyte, exp);
		$display("read test done");
	endtask
	task automatic bad_seq(input logic [7:0] pre, input logic [7:0] u1, input logic [7:0] u2, input logic [7:0] t);
		wr(EEA_SEL_DATA, 8'hc3);
		wr(EEA_SEL_CTRL, pre);
		wr(EEA_SEL_CTRL, u1, 1'b1);
		wr(EEA_SEL_CTRL, u2, 1'b1);
		wr(EEA_SEL_CTRL, t);
		idle();
		chk({ctl.write_trig, busy, hp}, 16'h0000);
		repeat (12) @(negedge clk_sys);
		chk(done, 1'b0);
		$display("refused write test done");
	endtask
	task automatic ce_hold(input logic [7:0] keep);
		ce = 1'b0;
		wr(EEA_SEL_ADDR_LO, ~keep);
		idle();
		chk(a_lo, keep);
		ce = 1'b1;
		$display("clock enable test done");
	endtask
	initial begin
		reset_check();
		do_write(2'h3, 8'h5a, 8'ha5, 1'b0);
		read_back(2'h3, 8'h5a, 8'ha5);
		bad_seq(8'h04, UNLOCK_SECOND, UNLOCK_FIRST, 8'h06);
		bad_seq(8'h00, UNLOCK_FIRST, UNLOCK_SECOND, 8'h06);
		bad_seq(8'h00, UNLOCK_FIRST, UNLOCK_SECOND, 8'h02);
		bad_seq(8'h04, 8'h00, 8'h00, 8'h06);
		bad_seq(8'h04, UNLOCK_FIRST, 8'hab, 8'h06);
		bad_seq(8'h84, UNLOCK_FIRST, UNLOCK_SECOND, 8'h86);
		read_back(2'h3, 8'h5a, 8'ha5);
		do_write(2'h0, 8'hff, 8'h69, 1'b1);
		read_back(2'h0, 8'hff, 8'h69);
		read_back(2'h3, 8'h5a, 8'ha5);
		ce_hold(8'h5a);
		tally_and_finish();
	end
endmodule // data_eeprom_access_control_tb_top
`default_nettype wire
